// *** include/itt_pkg.sv ***
// Shared constants, register map and tap decoding for the interval/timebase timer
package itt_pkg;

  // ****************************************************************
  // Register map: indices, byte address is four times the index
  // ****************************************************************
  localparam int          ADDR_W        = 18;
  localparam logic [15:0] IDX_MODE      = 16'hFFB0;
  localparam logic [15:0] IDX_COUNT     = 16'hFFB1;
  localparam logic [15:0] IDX_CLKSTOP   = 16'hFFFA;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'hFFC0;
  localparam logic [15:0] IDX_IRQ_MASK  = 16'hFFC1;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         MODE_BIT      = 3;
  localparam int         CLEAR_BIT     = 2;
  localparam int         FIXED_ONE_BIT = 4;
  localparam int         RUN_BIT       = 0;
  localparam int         OVF_BIT       = 0;
  localparam logic [3:0] MODE_RST      = 4'h0;
  localparam logic [7:0] COUNT_RST     = 8'h00;
  localparam logic [7:0] CLKSTOP_RST   = 8'hFF;
  localparam logic       IRQ_RST       = 1'b0;

  // ****************************************************************
  // Prescaler widths and timing
  // ****************************************************************
  localparam int    SYS_PS_W    = 13;
  localparam int    WATCH_PS_W  = 7;
  localparam longint WATCH_HZ   = 32768;
  localparam longint TCA_STEPS  = 256;
  localparam longint PERIOD0_US = 1000000;
  localparam longint PERIOD1_US = 500000;
  localparam longint PERIOD2_US = 250000;
  localparam longint PERIOD3_US = 31250;
  // Watch clocks per counter step for each overflow period
  localparam int WDIV0 = int'(WATCH_HZ * PERIOD0_US / 1000000 / TCA_STEPS);
  localparam int WDIV1 = int'(WATCH_HZ * PERIOD1_US / 1000000 / TCA_STEPS);
  localparam int WDIV2 = int'(WATCH_HZ * PERIOD2_US / 1000000 / TCA_STEPS);
  localparam int WDIV3 = int'(WATCH_HZ * PERIOD3_US / 1000000 / TCA_STEPS);

  // Number of low system prescaler bits that divide by the selected ratio
  function automatic int unsigned itt_sys_tap(input logic [2:0] code);
    case (code)
      3'h0:    return 13;
      3'h1:    return 12;
      3'h2:    return 11;
      3'h3:    return 9;
      3'h4:    return 8;
      3'h5:    return 7;
      3'h6:    return 5;
      default: return 3;
    endcase
  endfunction : itt_sys_tap

  // Watch clocks per counter step for the selected period
  function automatic int unsigned itt_watch_div(input logic [1:0] code);
    case (code)
      2'h0:    return WDIV0;
      2'h1:    return WDIV1;
      2'h2:    return WDIV2;
      default: return WDIV3;
    endcase
  endfunction : itt_watch_div

endpackage : itt_pkg

// *** verilog/itt_prescaler.sv ***
// Free-running binary prescaler with synchronous clear
`timescale 1ns/1ps
module itt_prescaler #(
  parameter int W = 13
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clear,
  input  wire logic         step,
  output logic [W-1:0]      count
);

  // ****************************************************************
  // Counter, clear has priority over stepping
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (step) begin
      count <= count + W'(1);
    end
  end

endmodule : itt_prescaler

// *** verilog/itt_timer.sv ***
// Interval timer and clock time base with APB registers and overflow interrupt
//
// Behaviour
// R1: Mode bit 0: count system prescaler tap chosen by three low select bits.
// R2: Mode bit 1, clear 0: count watch prescaler, four overflow periods.
// R3: Mode and clear bits both 1 reset counter and watch prescaler.
// R4: Eight-bit up-counter, read-only; bus writes never change it.
// R5: Counter overflow sets the overflow interrupt request flag.
// R6: Reset initialises the counter to zero.
// R7: Counter reads return its value in active mode, zero in subactive.
// R8: Software writes zeros to mode register bits 7 to 5.
// R9: Mode register bit 4 always reads one, writes ignored.
// R10: Module standby stops the timer independently of other blocks.
// R11: Clock at maximum count overflows, wraps to zero, keeps counting.
// R12: Interrupt output raised only while the overflow enable bit is one.
// R13: Run bit resets to one; writing zero halts the counter.
// R14: While run bit is zero the mode bit cannot be rewritten.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module itt_timer
  import itt_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              watch_clk_in,
  input  wire logic              cpu_subactive,
  output logic                   irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [3:0]            mode_sel;
  logic [7:0]            clk_stop;
  logic [7:0]            count;
  logic                  ovf_flag;
  logic                  ovf_en;
  logic                  w_meta;
  logic                  w_sync;
  logic                  w_prev;
  logic                  wtick;
  logic                  run;
  logic                  tb_mode;
  logic                  tb_clear;
  logic [SYS_PS_W-1:0]   sys_ps;
  logic [WATCH_PS_W-1:0] watch_ps;
  logic                  sys_tick;
  logic                  watch_tick;
  logic                  cnt_tick;
  logic                  overflow;
  logic                  access;
  logic                  wr;
  logic                  setup_rd;
  logic                  sel_mode;
  logic                  sel_count;
  logic                  sel_stop;
  logic                  sel_stat;
  logic                  sel_mask;
  logic                  mapped;
  logic [31:0]           next_prdata;

  // Address match against a register index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a == {idx, 2'b00};
  endfunction : hit

  // True when the low k bits of v are all ones
  function automatic logic low_ones(input logic [SYS_PS_W-1:0] v, input int unsigned k);
    logic [SYS_PS_W-1:0] m;
    m = SYS_PS_W'((1 << k) - 1);
    return (v & m) == m;
  endfunction : low_ones

  // ****************************************************************
  // Watch clock synchroniser and edge detect
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_meta <= 1'b0;
      w_sync <= 1'b0;
      w_prev <= 1'b0;
    end else begin
      w_meta <= watch_clk_in;
      w_sync <= w_meta;
      w_prev <= w_sync;
    end
  end

  assign wtick = w_sync & ~w_prev;

  // ****************************************************************
  // Mode decode and standby
  // ****************************************************************
  assign run      = clk_stop[RUN_BIT];                          // R10
  assign tb_mode  = mode_sel[MODE_BIT];
  assign tb_clear = mode_sel[MODE_BIT] & mode_sel[CLEAR_BIT];   // R3

  // ****************************************************************
  // Prescalers
  // ****************************************************************
  itt_prescaler #(.W(SYS_PS_W)) u_sys_ps (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (1'b0),
    .step    (run),
    .count   (sys_ps)
  );

  itt_prescaler #(.W(WATCH_PS_W)) u_watch_ps (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (tb_clear),                                        // R3
    .step    (run & wtick),
    .count   (watch_ps)
  );

  // Interval tap, halted in subactive mode
  assign sys_tick = run & ~cpu_subactive
                  & low_ones(sys_ps, itt_sys_tap(mode_sel[2:0])); // R1
  // Time base tap from the watch prescaler
  assign watch_tick = run & wtick
                    & low_ones({{(SYS_PS_W-WATCH_PS_W){1'b0}}, watch_ps},
                               $clog2(itt_watch_div(mode_sel[1:0]))); // R2

  // Counter input selection
  always_comb begin
    if (tb_mode) begin
      cnt_tick = watch_tick & ~tb_clear;                        // R2
    end else begin
      cnt_tick = sys_tick;                                      // R1
    end
  end

  assign overflow = cnt_tick & (count == 8'hFF);                // R11

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RST;                                       // R6
    end else if (tb_clear) begin
      count <= COUNT_RST;                                       // R3
    end else if (cnt_tick) begin
      count <= count + 8'h01;                                   // R4 R11
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign access    = psel & penable;
  assign wr        = access & pwrite;
  assign setup_rd  = psel & ~penable & ~pwrite;
  assign sel_mode  = hit(paddr, IDX_MODE);
  assign sel_count = hit(paddr, IDX_COUNT);
  assign sel_stop  = hit(paddr, IDX_CLKSTOP);
  assign sel_stat  = hit(paddr, IDX_IRQ_STAT);
  assign sel_mask  = hit(paddr, IDX_IRQ_MASK);
  assign mapped    = sel_mode | sel_count | sel_stop | sel_stat | sel_mask;
  assign pready    = 1'b1;
  assign pslverr   = access & ~mapped;

  // ****************************************************************
  // Mode register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sel <= MODE_RST;
    end else if (wr && sel_mode) begin
      mode_sel[2:0] <= pwdata[2:0];
      if (run) begin
        mode_sel[MODE_BIT] <= pwdata[MODE_BIT];                 // R14
      end
    end
  end

  // Clock stop register, run bit included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_stop <= CLKSTOP_RST;                                  // R13
    end else if (wr && sel_stop) begin
      clk_stop <= pwdata[7:0];                                  // R13
    end
  end

  // ****************************************************************
  // Interrupt status and enable
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag <= IRQ_RST;
    end else begin
      ovf_flag <= overflow                                      // R5
                | (ovf_flag & ~(wr & sel_stat & pwdata[OVF_BIT]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_en <= IRQ_RST;
    end else if (wr && sel_mask) begin
      ovf_en <= pwdata[OVF_BIT];
    end
  end

  assign irq = ovf_flag & ovf_en;                               // R12

  // ****************************************************************
  // Read data, captured in the setup cycle
  // ****************************************************************
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_mode) begin
      next_prdata[3:0]           = mode_sel;
      next_prdata[FIXED_ONE_BIT] = 1'b1;                        // R9
    end else if (sel_count) begin
      next_prdata[7:0] = cpu_subactive ? 8'h00 : count;         // R7
    end else if (sel_stop) begin
      next_prdata[7:0] = clk_stop;
    end else if (sel_stat) begin
      next_prdata[OVF_BIT] = ovf_flag;
    end else if (sel_mask) begin
      next_prdata[OVF_BIT] = ovf_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OVF_SETS_FLAG: assert property (overflow |=> ovf_flag) // R5
    else $error("overflow did not set the flag");
  AST_OVF_WRAPS: assert property (overflow && !tb_clear |=> count == 8'h00) // R11
    else $error("counter did not wrap to zero");
  AST_CLEAR_CODE: assert property (tb_clear |=> count == 8'h00 && watch_ps == '0) // R3
    else $error("clear code did not reset counter and watch prescaler");
  AST_STANDBY_HALT: assert property (!run && !tb_clear |=> $stable(count)) // R10
    else $error("counter moved in module standby");
  AST_MODE_LOCK: assert property (!run |=> mode_sel[MODE_BIT] == $past(mode_sel[MODE_BIT])) // R14
    else $error("mode bit changed while stopped");
  AST_READ_ONE: assert property (setup_rd && sel_mode |=> prdata[FIXED_ONE_BIT]) // R9
    else $error("fixed bit did not read as one");
  AST_NO_WRITE_COUNT: assert property (wr && sel_count && !cnt_tick && !tb_clear
                                       |=> $stable(count)) // R4
    else $error("bus write altered the counter");
  AST_SUB_READ: assert property (setup_rd && sel_count && cpu_subactive |=> prdata == 32'h0) // R7
    else $error("counter readable in subactive mode");
  AST_IRQ_GATED: assert property (!ovf_en |-> !irq) // R12
    else $error("interrupt raised while disabled");
  AST_DIV8_SPACING: assert property (sys_tick && mode_sel[2:0] == 3'h7 && run && !cpu_subactive
                                     |=> !sys_tick [*7]) // R1
    else $error("fastest tap stepped too early");
  AST_WATCH_STEP: assert property (tb_mode && !tb_clear && !wtick |=> $stable(count)) // R2
    else $error("time base stepped without a watch edge");

  COV_OVERFLOW: cover property (overflow && !tb_mode);
  COV_TB_OVERFLOW: cover property (overflow && tb_mode);
  COV_IRQ: cover property (irq);
  COV_STANDBY: cover property (!run ##1 run);

endmodule : itt_timer

// *** sim/tb_top.sv ***
// Self-checking testbench for the interval/timebase timer
`timescale 1ns/1ps
module tb_top
  import itt_pkg::*;
;
  // ****************************************************************
  // Stimulus signals and counters
  // ****************************************************************
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              watch_clk_in;
  logic              cpu_subactive;
  logic              irq;
  int                error_cnt;
  int                comparisons;

  itt_timer uut (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .watch_clk_in  (watch_clk_in),
    .cpu_subactive (cpu_subactive),
    .irq           (irq)
  );

  // System clock, 50 ns period
  always #25 pclk = ~pclk;

  // Slow watch clock, 20 system cycles per period, phase offset from the system clock
  localparam int WATCH_CYC = 20;
  initial begin
    watch_clk_in = 1'b0;
    #13;
    forever #500 watch_clk_in = ~watch_clk_in;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  // One APB transfer; entered right after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr_en, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("access cycles", 32'h1, 32'(n));
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [31:0] r);
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
  endtask : rd

  task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    rd(idx, r);
    chk(nm, exp, r);
  endtask : rdc

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    rdc("mode reset", IDX_MODE, 32'h00000010);
    rdc("count reset", IDX_COUNT, 32'h00000000);
    rdc("run reset", IDX_CLKSTOP, 32'h000000FF);
    rdc("status reset", IDX_IRQ_STAT, 32'h00000000);
    chk("irq reset", 32'h0, {31'h0, irq});
  endtask : test_reset

  // Each interval code: two steps over exactly two tap periods
  task automatic test_intervals();
    int          k_tab[8] = '{13, 12, 11, 9, 8, 7, 5, 3};
    logic [31:0] c1;
    logic [31:0] c2;
    for (int c = 0; c < 8; c++) begin
      wr(IDX_MODE, 8'(c));
      rdc("mode code", IDX_MODE, 32'h10 | 32'(c));
      rd(IDX_COUNT, c1);
      repeat (2 * (1 << k_tab[c]) - 3) @(posedge pclk);
      rd(IDX_COUNT, c2);
      chk("interval delta", 32'h2, {24'h0, 8'(c2[7:0] - c1[7:0])});
    end
  endtask : test_intervals

  task automatic test_overflow_irq();
    logic [31:0] c;
    int          n;
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_IRQ_STAT, 8'h01);
    n = 0;
    while (irq !== 1'b1 && n < 2100) begin
      @(posedge pclk);
      n++;
    end
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(IDX_COUNT, c);
    chk("count wrapped", 32'h1, {31'h0, c < 32'h2});
    rdc("status set", IDX_IRQ_STAT, 32'h1);
    wr(IDX_IRQ_MASK, 8'h00);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdc("status kept", IDX_IRQ_STAT, 32'h1);
    wr(IDX_IRQ_STAT, 8'h01);
    rdc("status cleared", IDX_IRQ_STAT, 32'h0);
  endtask : test_overflow_irq

  task automatic test_standby();
    logic [31:0] c1;
    wr(IDX_CLKSTOP, 8'hFE);
    rdc("run off", IDX_CLKSTOP, 32'hFE);
    rd(IDX_COUNT, c1);
    repeat (200) @(posedge pclk);
    rdc("halted", IDX_COUNT, c1);
    wr(IDX_COUNT, 8'h55);
    rdc("count ro", IDX_COUNT, c1);
    wr(IDX_MODE, 8'h0F);
    rdc("mode locked", IDX_MODE, 32'h17);
    wr(IDX_CLKSTOP, 8'hFF);
    cpu_subactive <= 1'b1;
    @(posedge pclk);
    rdc("subactive read", IDX_COUNT, 32'h0);
    cpu_subactive <= 1'b0;
    @(posedge pclk);
  endtask : test_standby

  // Time base codes 0 to 2: two steps over exactly two step periods, then code 3
  task automatic test_timebase();
    int          div_tab[3] = '{WDIV0, WDIV1, WDIV2};
    logic [31:0] c1;
    logic [31:0] c2;
    logic [7:0]  d;
    for (int c = 0; c < 3; c++) begin
      wr(IDX_MODE, 8'(8 + c));
      rdc("tb code", IDX_MODE, 32'h18 | 32'(c));
      rd(IDX_COUNT, c1);
      repeat (2 * div_tab[c] * WATCH_CYC - 3) @(posedge pclk);
      rd(IDX_COUNT, c2);
      chk("tb step delta", 32'h2, {24'h0, 8'(c2[7:0] - c1[7:0])});
    end
    wr(IDX_MODE, 8'h0B);
    rdc("tb mode", IDX_MODE, 32'h1B);
    rd(IDX_COUNT, c1);
    repeat (797) @(posedge pclk);
    rd(IDX_COUNT, c2);
    d = c2[7:0] - c1[7:0];
    chk("tb delta", 32'h1, {31'h0, d >= 8'h09 && d <= 8'h0B});
    wr(IDX_MODE, 8'h0C);
    rdc("tb clear", IDX_COUNT, 32'h0);
    repeat (200) @(posedge pclk);
    rdc("tb held", IDX_COUNT, 32'h0);
  endtask : test_timebase

  task automatic test_unmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b0, 16'h0000, 8'h00, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    apb(1'b1, 16'h0000, 8'h5A, r, e);
    chk("unmapped wr err", 32'h1, {31'h0, e});
  endtask : test_unmapped

  // ****************************************************************
  // Verdict, main sequence and watchdog
  // ****************************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    pclk          = 1'b0;
    presetn       = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = '0;
    pwdata        = 32'h00000000;
    cpu_subactive = 1'b0;
    error_cnt     = 0;
    comparisons   = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset();
    test_unmapped();
    test_intervals();
    test_overflow_irq();
    test_standby();
    test_timebase();
    give_verdict();
  end

  // Cuts a hang well beyond the expected run length
  initial begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end

endmodule : tb_top
